// file: include/gsfc_pkg.sv
// gsfc_pkg: shared constants and types of the sample FIFO control block
// assumes a 250 MHz system clock and an APB register bus with 32-bit data
package gsfc_pkg;

  // ***************************************************************
  // clock and sample-rate timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS      = 4;
  localparam int unsigned ODR_BASE_PERIOD_NS = 1250000;
  localparam int unsigned ODR_BASE_CYCLES    = ODR_BASE_PERIOD_NS / CLK_PERIOD_NS;

  // ***************************************************************
  // geometry
  // ***************************************************************
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned SAMPLE_W   = 16;
  localparam int unsigned CNT_W      = 6;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned ADDR_LSB   = 2;
  localparam int unsigned IDX_W      = ADDR_W - ADDR_LSB;

  // ***************************************************************
  // register indices, byte address is four times the index
  // ***************************************************************
  localparam logic [IDX_W-1:0] IDX_STATUS_MIRROR = 6'h00;
  localparam logic [IDX_W-1:0] IDX_DATA_XY       = 6'h01;
  localparam logic [IDX_W-1:0] IDX_DATA_Z        = 6'h02;
  localparam logic [IDX_W-1:0] IDX_FIFO_STATUS   = 6'h08;
  localparam logic [IDX_W-1:0] IDX_FIFO_SETUP    = 6'h09;
  localparam logic [IDX_W-1:0] IDX_CTRL_ONE      = 6'h13;

  // ***************************************************************
  // fields and reset values
  // ***************************************************************
  localparam int unsigned STAT_OVF_BIT   = 7;
  localparam int unsigned STAT_WMK_BIT   = 6;
  localparam int unsigned SETUP_MODE_LSB = 6;
  localparam int unsigned WML_W          = 6;
  localparam int unsigned PWR_ACTIVE_BIT = 1;
  localparam int unsigned RATE_LSB       = 2;
  localparam int unsigned RATE_W         = 3;
  localparam logic [1:0]  MODE_OFF       = 2'h0;
  localparam logic [1:0]  MODE_CIRC      = 2'h1;
  localparam logic [7:0]  SETUP_RST      = 8'h00;
  localparam logic [7:0]  CTRL_ONE_RST   = 8'h00;
  localparam logic [7:0]  CTRL_ONE_MASK  = 8'h1F;

  typedef enum logic [1:0]
  {
    APB_IDLE   = 2'b01,
    APB_ANSWER = 2'b10
  } gsfc_apb_e;

  typedef struct packed
  {
    logic [SAMPLE_W-1:0] z;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] x;
  } gsfc_entry_s;

endpackage : gsfc_pkg

// file: include/gsfc_mem_if.sv
// gsfc_mem_if: write and read port of the sample store
// assumes one clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface gsfc_mem_if #(parameter int unsigned AW = 5);
  logic                  we;
  logic [AW-1:0]         waddr;
  logic [AW-1:0]         raddr;
  gsfc_pkg::gsfc_entry_s wdata;
  gsfc_pkg::gsfc_entry_s rdata;

  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : gsfc_mem_if
`default_nettype wire

// file: hw/gsfc_mem.sv
// gsfc_mem: sample store, one three-axis entry per word, registered read
// assumes the controller never writes past the depth it was built for
`timescale 1ns/100ps
`default_nettype none
module gsfc_mem #(
  parameter int unsigned DEPTH = gsfc_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  gsfc_mem_if.mem  bus
);

  gsfc_pkg::gsfc_entry_s store [DEPTH];

  always_ff @(posedge clk)
  begin
    if (bus.we)
    begin
      store[bus.waddr] <= bus.wdata;
    end
    bus.rdata <= store[bus.raddr];
  end

endmodule : gsfc_mem
`default_nettype wire

// file: hw/gsfc_top.sv
// gsfc_top: sample FIFO control with APB register slave
// assumes synchronous inputs on SYS_CLK and an APB master that holds its request
//
// Function
// RULE1 - status byte readable at index 0x00 identical to the FIFO status register.
// RULE2 - entering active mode from standby or ready resets the FIFO status.
// RULE3 - sample arriving while 32 samples held sets overflow flag, status bit 7.
// RULE4 - overflow flag clears once the sample count drops below 32.
// RULE5 - watermark flag, status bit 6, set while count at or above level.
// RULE6 - watermark flag drops once count falls below the level.
// RULE7 - six-bit sample count in status bits 5:0, zero means empty.
// RULE8 - samples enter at the output data rate picked by rate select bits.
// RULE9 - host should change FIFO setup only in standby.
// RULE10 - mode field bits 7:6: 00 off, 01 circular, 1x stop.
// RULE11 - circular mode at full: oldest sample dropped, newest stored.
// RULE12 - stop mode at full: new samples refused, contents kept.
// RULE13 - host disables the FIFO before switching circular and stop.
// RULE14 - disabled FIFO is emptied, count back to zero.
// RULE15 - disabled FIFO clears the watermark flag.
// RULE16 - watermark level zero never raises the watermark flag.
// RULE17 - storage continues past the watermark level.
// RULE18 - watermark level held in setup bits 5:0, reset to zero.
// RULE19 - FIFO event output is overflow OR watermark.
// RULE20 - each entry holds X, Y and Z captured at one rate tick.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module gsfc_top #(
  parameter int unsigned ODR_BASE_CYCLES = gsfc_pkg::ODR_BASE_CYCLES,
  parameter int unsigned DEPTH           = gsfc_pkg::FIFO_DEPTH
) (
  input  wire logic                          SYS_CLK,
  input  wire logic                          RESETN,
  input  wire logic                          PSEL,
  input  wire logic                          PENABLE,
  input  wire logic                          PWRITE,
  input  wire logic [gsfc_pkg::ADDR_W-1:0]   PADDR,
  input  wire logic [gsfc_pkg::DATA_W-1:0]   PWDATA,
  output wire logic [gsfc_pkg::DATA_W-1:0]   PRDATA,
  output wire logic                          PREADY,
  output wire logic                          PSLVERR,
  input  wire logic [gsfc_pkg::SAMPLE_W-1:0] SAMPLE_X,
  input  wire logic [gsfc_pkg::SAMPLE_W-1:0] SAMPLE_Y,
  input  wire logic [gsfc_pkg::SAMPLE_W-1:0] SAMPLE_Z,
  output wire logic                          FIFO_EVENT
);

  localparam int unsigned    PW       = $clog2(DEPTH);
  localparam int unsigned    CW       = gsfc_pkg::CNT_W;
  localparam logic [CW-1:0]  FULL_CNT = CW'(DEPTH);

  // ***************************************************************
  // declarations
  // ***************************************************************
  gsfc_pkg::gsfc_apb_e           apb_st_r;
  gsfc_pkg::gsfc_apb_e           apb_st_nxt;
  logic                          pready_r;
  logic                          pready_nxt;
  logic                          pslverr_r;
  logic                          pslverr_nxt;
  logic [gsfc_pkg::DATA_W-1:0]   prdata_r;
  logic [gsfc_pkg::DATA_W-1:0]   prdata_nxt;
  logic [gsfc_pkg::DATA_W-1:0]   rd_val;
  logic                          hit;
  logic                          commit;
  logic                          wr_commit;
  logic                          pop_req;
  logic [gsfc_pkg::IDX_W-1:0]    reg_idx;
  logic [7:0]                    status_byte;
  logic [7:0]                    setup_r;
  logic [7:0]                    setup_nxt;
  logic [7:0]                    ctrl_r;
  logic [7:0]                    ctrl_nxt;
  logic [1:0]                    mode;
  logic                          fifo_on;
  logic                          circ;
  logic                          stop;
  logic                          active;
  logic                          enter_active;
  logic                          flush;
  logic [gsfc_pkg::RATE_W-1:0]   rate;
  logic [gsfc_pkg::WML_W-1:0]    wml;
  logic [31:0]                   tick_period;
  logic [31:0]                   tick_cnt_r;
  logic [31:0]                   tick_cnt_nxt;
  logic                          tick;
  logic                          push;
  logic                          pop;
  logic                          full_eff;
  logic                          accept;
  logic                          drop;
  logic                          hit_full;
  logic [PW-1:0]                 wr_ptr_r;
  logic [PW-1:0]                 wr_ptr_nxt;
  logic [PW-1:0]                 rd_ptr_r;
  logic [PW-1:0]                 rd_ptr_nxt;
  logic [CW-1:0]                 cnt_r;
  logic [CW-1:0]                 cnt_nxt;
  logic                          ovf_r;
  logic                          ovf_nxt;
  logic                          wmk_r;
  logic                          wmk_nxt;
  logic                          event_r;
  logic                          event_nxt;

  gsfc_mem_if #(.AW(PW)) mem_bus ();

  gsfc_mem #(
    .DEPTH (DEPTH)
  ) u_mem (
    .clk (SYS_CLK),
    .bus (mem_bus.mem)
  );

  // ***************************************************************
  // register read mux
  // ***************************************************************
  assign reg_idx     = PADDR[gsfc_pkg::ADDR_W-1:gsfc_pkg::ADDR_LSB];
  assign status_byte = {ovf_r, wmk_r, cnt_r};

  always_comb
  begin
    hit    = 1'b1;
    rd_val = 32'h0000_0000;
    case (reg_idx)
      gsfc_pkg::IDX_STATUS_MIRROR,
      gsfc_pkg::IDX_FIFO_STATUS:
      begin
        rd_val = {24'h00_0000, status_byte}; // RULE1
      end
      gsfc_pkg::IDX_DATA_XY:
      begin
        rd_val = {mem_bus.rdata.y, mem_bus.rdata.x};
      end
      gsfc_pkg::IDX_DATA_Z:
      begin
        rd_val = {16'h0000, mem_bus.rdata.z};
      end
      gsfc_pkg::IDX_FIFO_SETUP:
      begin
        rd_val = {24'h00_0000, setup_r};
      end
      gsfc_pkg::IDX_CTRL_ONE:
      begin
        rd_val = {24'h00_0000, ctrl_r};
      end
      default:
      begin
        hit = 1'b0;
      end
    endcase
  end

  // ***************************************************************
  // APB slave: answer one cycle into the access phase
  // ***************************************************************
  always_comb
  begin
    apb_st_nxt  = apb_st_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = prdata_r;
    commit      = 1'b0;
    case (apb_st_r)
      gsfc_pkg::APB_IDLE:
      begin
        if (PSEL && PENABLE)
        begin
          apb_st_nxt  = gsfc_pkg::APB_ANSWER;
          pready_nxt  = 1'b1;
          pslverr_nxt = !hit;
          prdata_nxt  = PWRITE ? 32'h0000_0000 : rd_val;
        end
      end
      gsfc_pkg::APB_ANSWER:
      begin
        apb_st_nxt = gsfc_pkg::APB_IDLE;
        commit     = PSEL && PENABLE;
      end
      default:
      begin
        apb_st_nxt = gsfc_pkg::APB_IDLE;
      end
    endcase
  end

  assign wr_commit = commit && PWRITE && hit;
  assign pop_req   = commit && !PWRITE && (reg_idx == gsfc_pkg::IDX_DATA_Z);

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      apb_st_r  <= gsfc_pkg::APB_IDLE;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      apb_st_r  <= apb_st_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // ***************************************************************
  // setup and control registers
  // ***************************************************************
  always_comb
  begin
    setup_nxt = setup_r;
    ctrl_nxt  = ctrl_r;
    if (wr_commit && (reg_idx == gsfc_pkg::IDX_FIFO_SETUP))
    begin
      setup_nxt = PWDATA[7:0]; // RULE18
    end
    if (wr_commit && (reg_idx == gsfc_pkg::IDX_CTRL_ONE))
    begin
      ctrl_nxt = PWDATA[7:0] & gsfc_pkg::CTRL_ONE_MASK;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      setup_r <= gsfc_pkg::SETUP_RST; // RULE18
      ctrl_r  <= gsfc_pkg::CTRL_ONE_RST;
    end
    else
    begin
      setup_r <= setup_nxt;
      ctrl_r  <= ctrl_nxt;
    end
  end

  assign mode         = setup_r[gsfc_pkg::SETUP_MODE_LSB +: 2];
  assign fifo_on      = (mode != gsfc_pkg::MODE_OFF); // RULE10
  assign circ         = (mode == gsfc_pkg::MODE_CIRC); // RULE10
  assign stop         = mode[1]; // RULE10
  assign wml          = setup_r[gsfc_pkg::WML_W-1:0];
  assign active       = ctrl_r[gsfc_pkg::PWR_ACTIVE_BIT];
  assign rate         = ctrl_r[gsfc_pkg::RATE_LSB +: gsfc_pkg::RATE_W];
  assign enter_active = ctrl_nxt[gsfc_pkg::PWR_ACTIVE_BIT] && !active;
  assign flush        = !fifo_on || enter_active; // RULE2 RULE14

  // ***************************************************************
  // output data rate divider
  // ***************************************************************
  assign tick_period = 32'(ODR_BASE_CYCLES) << rate;
  assign tick        = active && (tick_cnt_r == tick_period - 32'h0000_0001); // RULE8

  always_comb
  begin
    tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
    if (!active || tick)
    begin
      tick_cnt_nxt = 32'h0000_0000;
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      tick_cnt_r <= 32'h0000_0000;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_nxt;
    end
  end

  // ***************************************************************
  // FIFO pointers, count and flags
  // ***************************************************************
  assign push     = tick && fifo_on; // RULE8
  assign pop      = pop_req && fifo_on && (cnt_r != 6'h00);
  assign full_eff = (cnt_r == FULL_CNT) && !pop;
  assign accept   = push && !(full_eff && stop); // RULE12 RULE17
  assign drop     = push && full_eff && circ; // RULE11
  assign hit_full = push && full_eff; // RULE3

  always_comb
  begin
    cnt_nxt    = cnt_r + CW'(accept) - CW'(pop) - CW'(drop);
    wr_ptr_nxt = accept ? wr_ptr_r + PW'(1) : wr_ptr_r;
    rd_ptr_nxt = (pop || drop) ? rd_ptr_r + PW'(1) : rd_ptr_r; // RULE11
    ovf_nxt    = hit_full || (ovf_r && (cnt_nxt == FULL_CNT)); // RULE3 RULE4
    wmk_nxt    = (wml != 6'h00) && (cnt_nxt >= wml); // RULE5 RULE6 RULE16
    if (flush)
    begin
      cnt_nxt    = 6'h00; // RULE14
      wr_ptr_nxt = PW'(0);
      rd_ptr_nxt = PW'(0);
      ovf_nxt    = 1'b0;
      wmk_nxt    = 1'b0; // RULE15
    end
    event_nxt = ovf_nxt || wmk_nxt; // RULE19
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!RESETN)
    begin
      cnt_r    <= 6'h00; // RULE7
      wr_ptr_r <= PW'(0);
      rd_ptr_r <= PW'(0);
      ovf_r    <= 1'b0;
      wmk_r    <= 1'b0;
      event_r  <= 1'b0;
    end
    else
    begin
      cnt_r    <= cnt_nxt; // RULE7
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      ovf_r    <= ovf_nxt;
      wmk_r    <= wmk_nxt;
      event_r  <= event_nxt;
    end
  end

  // ***************************************************************
  // sample store hookup, all three axes in one entry
  // ***************************************************************
  assign mem_bus.we      = accept;
  assign mem_bus.waddr   = wr_ptr_r;
  assign mem_bus.wdata.x = SAMPLE_X; // RULE20
  assign mem_bus.wdata.y = SAMPLE_Y; // RULE20
  assign mem_bus.wdata.z = SAMPLE_Z; // RULE20
  assign mem_bus.raddr   = rd_ptr_r;

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign PRDATA     = prdata_r;
  assign PREADY     = pready_r;
  assign PSLVERR    = pslverr_r;
  assign FIFO_EVENT = event_r;

endmodule : gsfc_top
`default_nettype wire

// file: verif/gsfc_top_sva.sv
// gsfc_top_sva: port-level checks of the sample FIFO control block
// assumes APB master that holds its request until pready is sampled
`timescale 1ns/100ps
`default_nettype none
module gsfc_top_sva (
  input wire logic                        SYS_CLK,
  input wire logic                        RESETN,
  input wire logic                        PSEL,
  input wire logic                        PENABLE,
  input wire logic                        PWRITE,
  input wire logic [gsfc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [gsfc_pkg::DATA_W-1:0] PRDATA,
  input wire logic                        PREADY,
  input wire logic                        PSLVERR,
  input wire logic                        FIFO_EVENT
);
  logic [5:0] idx;
  logic       mapped;
  logic       stat_rd;

  assign idx = PADDR[7:2];
  assign mapped = idx inside {6'h00, 6'h01, 6'h02, 6'h08, 6'h09, 6'h13};
  assign stat_rd = PREADY && !PWRITE && (idx == 6'h00 || idx == 6'h08);

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESETN);

  sequence setup_s;
    PSEL && !PENABLE ##1 PSEL && PENABLE;
  endsequence
  sequence answer_s;
    PREADY ##1 !PREADY;
  endsequence

  answer_time_a: assert property (setup_s |=> answer_s)
    else $error("answer not one cycle after first access");
  no_early_a: assert property (PSEL && !PENABLE |=> !PREADY)
    else $error("ready during setup");
  no_stray_a: assert property (!PSEL |=> !PREADY)
    else $error("ready without select");
  unmapped_err_a: assert property (PREADY && !mapped |-> PSLVERR)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (PREADY && mapped |-> !PSLVERR)
    else $error("mapped access flagged error");
  write_zero_a: assert property (PREADY && PWRITE |-> PRDATA == 32'h0)
    else $error("read data not zero on write");
  count_range_a: assert property (stat_rd |-> PRDATA[31:8] == 24'h0 && PRDATA[5:0] <= 6'h20)
    else $error("status count out of range");
  ovf_full_a: assert property (stat_rd && PRDATA[7] |-> PRDATA[5:0] == 6'h20)
    else $error("overflow without full count");
  wmk_nonzero_a: assert property (stat_rd && PRDATA[6] |-> PRDATA[5:0] != 6'h0)
    else $error("watermark with empty buffer");
  event_or_a: assert property (stat_rd |-> $past(FIFO_EVENT) == (PRDATA[7] || PRDATA[6]))
    else $error("event output not overflow or watermark");
endmodule : gsfc_top_sva

bind gsfc_top gsfc_top_sva u_sva (
  .SYS_CLK (SYS_CLK),
  .RESETN  (RESETN),
  .PSEL    (PSEL),
  .PENABLE (PENABLE),
  .PWRITE  (PWRITE),
  .PADDR   (PADDR),
  .PRDATA  (PRDATA),
  .PREADY  (PREADY),
  .PSLVERR (PSLVERR),
  .FIFO_EVENT (FIFO_EVENT)
);
`default_nettype wire

// file: verif/gsfc_sample_src.sv
// gsfc_sample_src: sensor front end stand-in, new three-axis set every cycle
// assumes the block captures all three axes at one edge
`timescale 1ns/100ps
`default_nettype none
module gsfc_sample_src (
  input  wire logic        clk,
  output var  logic [15:0] x,
  output var  logic [15:0] y,
  output var  logic [15:0] z
);
  // axes tied to one stamp so a mixed entry shows up
  initial
  begin
    x = 16'h0000;
    y = 16'hFFFF;
    z = 16'h1000;
  end
  always @(posedge clk)
  begin
    x <= x + 16'h0001;
    y <= ~(x + 16'h0001);
    z <= x + 16'h1001;
  end
endmodule : gsfc_sample_src
`default_nettype wire

// file: verif/gsfc_top_tb.sv
// gsfc_top_tb: self-checking bench of the sample FIFO control block
// assumes ODR_BASE_CYCLES of 8, so rate 0 gives a tick every 8 cycles
`timescale 1ns/100ps
`default_nettype none
module gsfc_top_tb;
  logic        sys_clk, resetn, psel, penable, pwrite, pready, pslverr, fifo_event, err_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [15:0] sx, sy, sz, stamp, x0, x1;
  int          fail_count, total_checks;

  gsfc_sample_src src (.clk(sys_clk), .x(sx), .y(sy), .z(sz));
  gsfc_top #(.ODR_BASE_CYCLES(8), .DEPTH(32)) dut (
    .SYS_CLK(sys_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SAMPLE_X(sx), .SAMPLE_Y(sy),
    .SAMPLE_Z(sz), .FIFO_EVENT(fifo_event));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ***************************************************************
  // bus cycle and compare helpers
  // ***************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
  begin
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
  begin
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1);
    chk("wait", 2, n);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  end
  endtask : apb

  task automatic st(input logic [7:0] e);
  begin
    apb(1'b0, 8'h20, 32'h0);
    chk("status", {24'h0, e}, rd_q);
  end
  endtask : st

  task automatic pop(output logic [15:0] x);
  begin
    apb(1'b0, 8'h04, 32'h0);
    x = rd_q[15:0];
    chk("pair_y", {16'h0, ~x}, {16'h0, rd_q[31:16]});
    apb(1'b0, 8'h08, 32'h0);
    chk("pair_z", {16'h0, x + 16'h1000}, rd_q);
  end
  endtask : pop

  task automatic run(input logic [7:0] ctl, input int cyc);
  begin
    stamp = sx;
    apb(1'b1, 8'h4C, {24'h0, ctl});
    repeat (cyc) @(posedge sys_clk);
    apb(1'b1, 8'h4C, 32'h0);
  end
  endtask : run

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_regs;
  begin
    apb(1'b0, 8'h24, 32'h0);
    chk("setup_rst", 32'h0, rd_q);
    st(8'h00);
    apb(1'b1, 8'h20, 32'hFF);
    st(8'h00);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 1, {31'h0, err_q});
    apb(1'b1, 8'h24, 32'hC4);
    apb(1'b0, 8'h24, 32'h0);
    chk("setup_rw", 32'hC4, rd_q);
    $display("test regs done");
  end
  endtask : t_regs

  task automatic t_stop;
  begin
    run(8'h02, 320);
    st(8'hE0);
    apb(1'b0, 8'h00, 32'h0);
    chk("mirror", 32'hE0, rd_q);
    chk("event", 1, {31'h0, fifo_event});
    pop(x0);
    pop(x1);
    chk("stop_keep", 1, {31'h0, (x0 - stamp) < 16'd24});
    chk("spacing", 32'h8, {16'h0, x1 - x0});
    st(8'h5E);
    repeat (26) pop(x1);
    st(8'h44);
    pop(x1);
    st(8'h03);
    chk("event", 0, {31'h0, fifo_event});
    apb(1'b1, 8'h4C, 32'h02);
    st(8'h00);
    repeat (80) @(posedge sys_clk);
    apb(1'b1, 8'h4C, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("wmk_on", 1, {31'h0, rd_q[6]});
    apb(1'b1, 8'h24, 32'h0);
    st(8'h00);
    chk("event", 0, {31'h0, fifo_event});
    $display("test stop done");
  end
  endtask : t_stop

  task automatic t_circ;
  begin
    apb(1'b1, 8'h24, 32'h40);
    run(8'h02, 320);
    st(8'hA0);
    chk("event", 1, {31'h0, fifo_event});
    pop(x0);
    chk("circ_drop", 1, {31'h0, (x0 - stamp) > 16'd40});
    apb(1'b1, 8'h24, 32'h0);
    $display("test circular done");
  end
  endtask : t_circ

  task automatic t_rate;
  begin
    apb(1'b1, 8'h24, 32'h80);
    run(8'h06, 100);
    pop(x0);
    pop(x1);
    chk("spacing", 32'h10, {16'h0, x1 - x0});
    apb(1'b1, 8'h24, 32'h0);
    $display("test rate done");
  end
  endtask : t_rate

  task automatic results;
  begin
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask : results

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    results();
  end

  initial
  begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_regs();
    t_stop();
    t_circ();
    t_rate();
    results();
  end
endmodule : gsfc_top_tb
`default_nettype wire
